// ---- design/pmw_power_ctrl.sv ----
/*
 * pmw_power_ctrl: power mode, clock source and low power wake controller
 * with an AXI4-Lite register slave.
 * assumes: all inputs synchronous to CLK_I; the analog wake comparator
 * output is high while the wake pin is below the input low threshold.
 */
// What this block does
// - idle select bit gates CPU clock
// - two-bit field selects one of three sources
// - run/idle any source, sleep none
// - source write switches once new source ready
// - sleep instruction enters idle, sleep or deep sleep
// - idle select resets clear, gives sleep
// - sleep stops oscillator, clears source status
// - watchdog RC and timer1 survive sleep
// - wake waits for source or runs internal
// - primary running flag when primary clocks device
// - wake leaves idle select and source unchanged
// - preset bits alone decide sleep target mode
// - wake pin low raises interrupt and resumes
// - sleep wake by pin sets level flag
// - deep sleep wake by pin sets deep flag bit5
// - in sleep only wake output drives pin
`timescale 1ns/10ps

module pmw_power_ctrl #(
	parameter int START_W = 8,
	parameter logic [START_W-1:0] PRI_START_CYC = 8'h40,
	parameter logic [START_W-1:0] T1_START_CYC = 8'h20,
	parameter logic [START_W-1:0] INT_START_CYC = 8'h04
) (
	input wire logic CLK_I,
	input wire logic SRST_I,
	// axi4-lite slave
	input wire logic [7:0] S_AXI_AWADDR_I,
	input wire logic S_AXI_AWVALID_I,
	output logic S_AXI_AWREADY_O,
	input wire logic [31:0] S_AXI_WDATA_I,
	input wire logic [3:0] S_AXI_WSTRB_I,
	input wire logic S_AXI_WVALID_I,
	output logic S_AXI_WREADY_O,
	output logic [1:0] S_AXI_BRESP_O,
	output logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic [7:0] S_AXI_ARADDR_I,
	input wire logic S_AXI_ARVALID_I,
	output logic S_AXI_ARREADY_O,
	output logic [31:0] S_AXI_RDATA_O,
	output logic [1:0] S_AXI_RRESP_O,
	output logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	// core events
	input wire logic SLEEP_EXEC_I,
	input wire logic WAKE_INT_I,
	input wire logic WAKE_RST_I,
	input wire logic WDT_TIMEOUT_I,
	input wire logic ANALOG_WAKE_LOW_I,
	// clock control
	output logic CPU_CLK_EN_O,
	output logic PERIPH_CLK_EN_O,
	output logic [1:0] SYS_CLK_SEL_O,
	output logic PRI_OSC_EN_O,
	output logic T1_OSC_EN_O,
	output logic INT_OSC_EN_O,
	output logic RC_OSC_EN_O,
	// low power wake
	output logic ULP_SINK_EN_O,
	output logic ULP_WAKE_OUT_O,
	output logic REMAP_OTHERS_EN_O,
	output logic ULP_IRQ_O,
	output logic RESUME_O
);

	// ==========================================================
	// software registers
	logic idle_sel_reg;
	logic [1:0] csel_reg;
	logic wdt_sel_reg;
	logic ulp_en_reg;
	logic ulp_sink_reg;
	logic ulp_lvl_reg;
	logic ds_arm_reg;
	logic two_speed_reg;
	logic fail_safe_clock_monitor_reg;
	logic t1_en_reg;
	logic [2:0] posc_cfg_reg;
	logic ds_ulp_reg;

	// ==========================================================
	// mode state
	pmw_pkg::pmw_mode_e mode_reg;
	pmw_pkg::pmw_mode_e mode_next;
	logic [1:0] act_src_reg;
	logic [1:0] act_src_next;
	logic ulp_low_reg;

	// ==========================================================
	// axi write channel
	logic aw_hold_reg;
	logic w_hold_reg;
	logic [7:0] waddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_go;
	logic wr_b0;
	logic wr_osc;
	logic wr_wdt;
	logic wr_cfg;
	logic wr_ds;
	logic wr_hit;

	assign S_AXI_AWREADY_O = !aw_hold_reg;
	assign S_AXI_WREADY_O = !w_hold_reg;
	assign wr_go = aw_hold_reg && w_hold_reg && !S_AXI_BVALID_O;
	assign wr_b0 = wr_go && wstrb_reg[0];
	assign wr_osc = (waddr_reg == pmw_pkg::OSC_CTRL_ADDR);
	assign wr_wdt = (waddr_reg == pmw_pkg::WDT_CTRL_ADDR);
	assign wr_cfg = (waddr_reg == pmw_pkg::PWR_CFG_ADDR);
	assign wr_ds = (waddr_reg == pmw_pkg::DS_WAKE_ADDR);
	assign wr_hit = wr_osc || wr_wdt || wr_cfg || wr_ds || (waddr_reg == pmw_pkg::STATUS_ADDR);

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			S_AXI_BVALID_O <= 1'b0;
			S_AXI_BRESP_O <= pmw_pkg::RESP_OKAY;
		end else begin
			if (S_AXI_AWVALID_I && !aw_hold_reg) begin
				aw_hold_reg <= 1'b1;
				waddr_reg <= S_AXI_AWADDR_I;
			end
			if (S_AXI_WVALID_I && !w_hold_reg) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= S_AXI_WDATA_I;
				wstrb_reg <= S_AXI_WSTRB_I;
			end
			if (wr_go) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				S_AXI_BVALID_O <= 1'b1;
				S_AXI_BRESP_O <= wr_hit ? pmw_pkg::RESP_OKAY : pmw_pkg::RESP_DECERR;
			end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
				S_AXI_BVALID_O <= 1'b0;
			end
		end
	end

	// ==========================================================
	// low power wake detection
	logic ulp_fall;
	logic in_sleep;
	logic ulp_wake;
	logic set_lvl;
	logic set_ds;

	assign ulp_fall = ulp_en_reg && ANALOG_WAKE_LOW_I && !ulp_low_reg;
	assign in_sleep = (mode_reg == pmw_pkg::PMW_SLEEP);
	assign ulp_wake = ulp_fall && (in_sleep || mode_reg == pmw_pkg::PMW_DEEP);
	assign set_lvl = ulp_fall && in_sleep;
	assign set_ds = ulp_fall && (mode_reg == pmw_pkg::PMW_DEEP);

	// ==========================================================
	// control register writes
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			idle_sel_reg <= 1'b0;
			csel_reg <= pmw_pkg::SRC_PRIMARY;
			wdt_sel_reg <= 1'b0;
			ulp_en_reg <= 1'b0;
			ulp_sink_reg <= 1'b0;
			ds_arm_reg <= 1'b0;
			two_speed_reg <= 1'b0;
			fail_safe_clock_monitor_reg <= 1'b0;
			t1_en_reg <= 1'b0;
			posc_cfg_reg <= pmw_pkg::POSC_CFG_RST;
		end else if (wr_b0) begin
			if (wr_osc) begin
				idle_sel_reg <= wdata_reg[pmw_pkg::IDLE_SEL_BIT];
				csel_reg <= wdata_reg[pmw_pkg::CSEL_LSB +: 2];
			end
			if (wr_wdt) begin
				wdt_sel_reg <= wdata_reg[pmw_pkg::WDT_SEL_BIT];
				ulp_en_reg <= wdata_reg[pmw_pkg::ULP_EN_BIT];
				ulp_sink_reg <= wdata_reg[pmw_pkg::ULP_SINK_BIT];
			end
			if (wr_cfg) begin
				ds_arm_reg <= wdata_reg[pmw_pkg::DS_ARM_BIT];
				two_speed_reg <= wdata_reg[pmw_pkg::TWO_SPEED_BIT];
				fail_safe_clock_monitor_reg <= wdata_reg[pmw_pkg::FAIL_SAFE_CLOCK_MONITOR_BIT];
				t1_en_reg <= wdata_reg[pmw_pkg::T1_OSC_EN_BIT];
				posc_cfg_reg <= wdata_reg[pmw_pkg::POSC_CFG_LSB +: 3];
			end
		end
	end

	// sticky flags, write one clears, set wins
	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			ulp_lvl_reg <= 1'b0;
			ds_ulp_reg <= 1'b0;
			ulp_low_reg <= 1'b0;
		end else begin
			ulp_low_reg <= ulp_en_reg && ANALOG_WAKE_LOW_I;
			if (set_lvl) begin
				ulp_lvl_reg <= 1'b1;
			end else if (wr_b0 && wr_wdt && wdata_reg[pmw_pkg::ULP_LVL_BIT]) begin
				ulp_lvl_reg <= 1'b0;
			end
			if (set_ds) begin
				ds_ulp_reg <= 1'b1;
			end else if (wr_b0 && wr_ds && wdata_reg[pmw_pkg::DS_ULP_BIT]) begin
				ds_ulp_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// oscillator start-up
	logic pri_en;
	logic t1_en;
	logic int_en;
	logic pri_rdy;
	logic t1_rdy;
	logic int_rdy;
	logic sel_rdy;
	logic clocked_mode;
	logic fast_start;

	assign clocked_mode = (mode_reg == pmw_pkg::PMW_RUN) || (mode_reg == pmw_pkg::PMW_IDLE)
		|| (mode_reg == pmw_pkg::PMW_WAKE);
	assign fast_start = two_speed_reg || fail_safe_clock_monitor_reg;
	// sleep modes keep no source running except timer1 when t1_en_reg is set outside deep sleep
	assign pri_en = clocked_mode && (csel_reg == pmw_pkg::SRC_PRIMARY || act_src_reg == pmw_pkg::SRC_PRIMARY);
	assign t1_en = (clocked_mode && (csel_reg == pmw_pkg::SRC_TIMER1 || act_src_reg == pmw_pkg::SRC_TIMER1))
		|| (t1_en_reg && mode_reg != pmw_pkg::PMW_DEEP);
	assign int_en = clocked_mode && (csel_reg[1] || act_src_reg[1] || (mode_reg == pmw_pkg::PMW_WAKE && fast_start));

	pmw_osc_ready #(
		.CNT_W(START_W),
		.START_CYC(PRI_START_CYC)
	) u_pri_ready (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.en_i(pri_en),
		.ready_o(pri_rdy)
	);

	pmw_osc_ready #(
		.CNT_W(START_W),
		.START_CYC(T1_START_CYC)
	) u_t1_ready (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.en_i(t1_en),
		.ready_o(t1_rdy)
	);

	pmw_osc_ready #(
		.CNT_W(START_W),
		.START_CYC(INT_START_CYC)
	) u_int_ready (
		.clk_i(CLK_I),
		.srst_i(SRST_I),
		.en_i(int_en),
		.ready_o(int_rdy)
	);

	assign sel_rdy = (csel_reg == pmw_pkg::SRC_PRIMARY) ? pri_rdy :
		(csel_reg == pmw_pkg::SRC_TIMER1) ? t1_rdy : int_rdy;

	// ==========================================================
	// mode machine
	logic any_wake;

	assign any_wake = WAKE_INT_I || WAKE_RST_I || WDT_TIMEOUT_I || ulp_wake;

	always_comb begin
		mode_next = mode_reg;
		act_src_next = act_src_reg;
		case (mode_reg)
			pmw_pkg::PMW_RUN: begin
				if (SLEEP_EXEC_I) begin
					if (idle_sel_reg) begin
						mode_next = pmw_pkg::PMW_IDLE;
					end else if (ds_arm_reg) begin
						mode_next = pmw_pkg::PMW_DEEP;
					end else begin
						mode_next = pmw_pkg::PMW_SLEEP;
					end
				end
				if (csel_reg != act_src_reg && sel_rdy) begin
					act_src_next = csel_reg;
				end
			end
			pmw_pkg::PMW_IDLE: begin
				if (any_wake) begin
					mode_next = pmw_pkg::PMW_RUN;
				end
				if (csel_reg != act_src_reg && sel_rdy) begin
					act_src_next = csel_reg;
				end
			end
			pmw_pkg::PMW_SLEEP, pmw_pkg::PMW_DEEP: begin
				if (any_wake) begin
					mode_next = pmw_pkg::PMW_WAKE;
				end
			end
			pmw_pkg::PMW_WAKE: begin
				// hold or run internal until ready
				if (sel_rdy) begin
					mode_next = pmw_pkg::PMW_RUN;
					act_src_next = csel_reg;
				end else if (fast_start) begin
					act_src_next = pmw_pkg::SRC_INTERNAL;
				end
			end
			default: begin
				mode_next = pmw_pkg::PMW_RUN;
			end
		endcase
	end

	// ==========================================================
	// registered outputs
	logic cpu_clk_next;
	logic pri_running;
	logic wake_done;

	assign cpu_clk_next = (mode_next == pmw_pkg::PMW_RUN)
		|| (mode_next == pmw_pkg::PMW_WAKE && fast_start && int_rdy);
	assign pri_running = clocked_mode && act_src_reg == pmw_pkg::SRC_PRIMARY && pri_rdy;
	assign wake_done = (mode_reg != pmw_pkg::PMW_RUN) && (mode_next == pmw_pkg::PMW_RUN);

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			mode_reg <= pmw_pkg::PMW_RUN;
			act_src_reg <= pmw_pkg::SRC_PRIMARY;
			CPU_CLK_EN_O <= 1'b0;
			PERIPH_CLK_EN_O <= 1'b0;
			SYS_CLK_SEL_O <= pmw_pkg::SRC_PRIMARY;
			PRI_OSC_EN_O <= 1'b0;
			T1_OSC_EN_O <= 1'b0;
			INT_OSC_EN_O <= 1'b0;
			RC_OSC_EN_O <= 1'b0;
			ULP_SINK_EN_O <= 1'b0;
			ULP_WAKE_OUT_O <= 1'b0;
			REMAP_OTHERS_EN_O <= 1'b1;
			ULP_IRQ_O <= 1'b0;
			RESUME_O <= 1'b0;
		end else begin
			mode_reg <= mode_next;
			act_src_reg <= act_src_next;
			CPU_CLK_EN_O <= cpu_clk_next;
			PERIPH_CLK_EN_O <= (mode_next == pmw_pkg::PMW_RUN) || (mode_next == pmw_pkg::PMW_IDLE);
			SYS_CLK_SEL_O <= act_src_next;
			PRI_OSC_EN_O <= pri_en;
			T1_OSC_EN_O <= t1_en;
			INT_OSC_EN_O <= int_en;
			RC_OSC_EN_O <= wdt_sel_reg;
			ULP_SINK_EN_O <= ulp_en_reg && ulp_sink_reg;
			// wake detect alone on pin in sleep
			ULP_WAKE_OUT_O <= ulp_en_reg && ANALOG_WAKE_LOW_I;
			REMAP_OTHERS_EN_O <= (mode_next != pmw_pkg::PMW_SLEEP);
			ULP_IRQ_O <= ulp_fall;
			RESUME_O <= wake_done;
		end
	end

	// ==========================================================
	// axi read channel
	logic [31:0] rd_word;
	logic rd_hit;
	logic [7:0] ar;

	assign ar = S_AXI_ARADDR_I;
	assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
	assign rd_hit = (ar == pmw_pkg::OSC_CTRL_ADDR) || (ar == pmw_pkg::WDT_CTRL_ADDR)
		|| (ar == pmw_pkg::PWR_CFG_ADDR) || (ar == pmw_pkg::DS_WAKE_ADDR) || (ar == pmw_pkg::STATUS_ADDR);

	// primary and internal ready bits read zero in sleep since readiness drops with the enables; timer1 ready stays while t1_en_reg holds it on
	always_comb begin
		rd_word = 32'h0000_0000;
		if (ar == pmw_pkg::OSC_CTRL_ADDR) begin
			rd_word[pmw_pkg::IDLE_SEL_BIT] = idle_sel_reg;
			rd_word[pmw_pkg::PRI_RUN_BIT] = pri_running;
			rd_word[pmw_pkg::CSEL_LSB +: 2] = csel_reg;
		end else if (ar == pmw_pkg::WDT_CTRL_ADDR) begin
			rd_word[pmw_pkg::WDT_SEL_BIT] = wdt_sel_reg;
			rd_word[pmw_pkg::ULP_EN_BIT] = ulp_en_reg;
			rd_word[pmw_pkg::ULP_SINK_BIT] = ulp_sink_reg;
			rd_word[pmw_pkg::ULP_LVL_BIT] = ulp_lvl_reg;
		end else if (ar == pmw_pkg::PWR_CFG_ADDR) begin
			rd_word[pmw_pkg::DS_ARM_BIT] = ds_arm_reg;
			rd_word[pmw_pkg::TWO_SPEED_BIT] = two_speed_reg;
			rd_word[pmw_pkg::FAIL_SAFE_CLOCK_MONITOR_BIT] = fail_safe_clock_monitor_reg;
			rd_word[pmw_pkg::T1_OSC_EN_BIT] = t1_en_reg;
			rd_word[pmw_pkg::POSC_CFG_LSB +: 3] = posc_cfg_reg;
		end else if (ar == pmw_pkg::DS_WAKE_ADDR) begin
			rd_word[pmw_pkg::DS_ULP_BIT] = ds_ulp_reg;
		end else if (ar == pmw_pkg::STATUS_ADDR) begin
			rd_word[pmw_pkg::MODE_LSB +: 3] = mode_reg;
			rd_word[pmw_pkg::ACT_SRC_LSB +: 2] = act_src_reg;
			rd_word[pmw_pkg::RDY_LSB +: 3] = {int_rdy, t1_rdy, pri_rdy};
		end
	end

	always_ff @(posedge CLK_I) begin
		if (SRST_I) begin
			S_AXI_RVALID_O <= 1'b0;
			S_AXI_RDATA_O <= 32'h0000_0000;
			S_AXI_RRESP_O <= pmw_pkg::RESP_OKAY;
		end else if (S_AXI_ARVALID_I && !S_AXI_RVALID_O) begin
			S_AXI_RVALID_O <= 1'b1;
			S_AXI_RDATA_O <= rd_word;
			S_AXI_RRESP_O <= rd_hit ? pmw_pkg::RESP_OKAY : pmw_pkg::RESP_DECERR;
		end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
			S_AXI_RVALID_O <= 1'b0;
		end
	end

endmodule

// ---- design/pmw_pkg.sv ----
/*
 * pmw_pkg: register map, field positions, reset values and encodings of the
 * power mode and wake controller.
 * assumes: 32-bit AXI4-Lite register bus, one aligned word per register.
 */
package pmw_pkg;

	// ==========================================================
	// register byte addresses
	localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
	localparam logic [7:0] WDT_CTRL_ADDR = 8'h04;
	localparam logic [7:0] PWR_CFG_ADDR = 8'h08;
	localparam logic [7:0] DS_WAKE_ADDR = 8'h0C;
	localparam logic [7:0] STATUS_ADDR = 8'h10;

	// ==========================================================
	// oscillator_control_reg fields
	localparam int IDLE_SEL_BIT = 7;
	localparam int PRI_RUN_BIT = 3;
	localparam int CSEL_LSB = 0;

	// watchdog_control_reg fields
	localparam int WDT_SEL_BIT = 0;
	localparam int ULP_EN_BIT = 1;
	localparam int ULP_SINK_BIT = 2;
	localparam int ULP_LVL_BIT = 5;

	// power configuration fields
	localparam int DS_ARM_BIT = 0;
	localparam int TWO_SPEED_BIT = 1;
	localparam int FAIL_SAFE_CLOCK_MONITOR_BIT = 2;
	localparam int T1_OSC_EN_BIT = 3;
	localparam int POSC_CFG_LSB = 4;

	// deep_sleep_wake_source_reg fields
	localparam int DS_ULP_BIT = 5;

	// status fields
	localparam int MODE_LSB = 0;
	localparam int ACT_SRC_LSB = 4;
	localparam int RDY_LSB = 8;

	// ==========================================================
	// clock source encodings of clock_source_select
	localparam logic [1:0] SRC_PRIMARY = 2'h0;
	localparam logic [1:0] SRC_TIMER1 = 2'h1;
	localparam logic [1:0] SRC_INTERNAL = 2'h2;
	localparam logic [2:0] POSC_CFG_RST = 3'h0;

	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		PMW_RUN,
		PMW_IDLE,
		PMW_SLEEP,
		PMW_DEEP,
		PMW_WAKE
	} pmw_mode_e;

endpackage

// ---- design/pmw_osc_ready.sv ----
/*
 * pmw_osc_ready: start-up delay of one oscillator; ready rises after the
 * enable has been held for START_CYC cycles and drops with the enable.
 * assumes: enable synchronous to CLK_I.
 */
`timescale 1ns/10ps

module pmw_osc_ready #(
	parameter int CNT_W = 8,
	parameter logic [CNT_W-1:0] START_CYC = 8'h10
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic en_i,
	output logic ready_o
);

	// ==========================================================
	// start-up counter
	logic [CNT_W-1:0] cnt_reg;
	logic done;

	assign done = (cnt_reg >= START_CYC);

	always_ff @(posedge clk_i) begin
		if (srst_i || !en_i) begin
			cnt_reg <= '0;
			ready_o <= 1'b0;
		end else begin
			if (!done) begin
				cnt_reg <= cnt_reg + 1'b1;
			end
			ready_o <= done;
		end
	end

endmodule

// ---- sim/pmw_power_ctrl_checker.sv ----
/*
 * pmw_power_ctrl_checker: port-level assertions of the power mode controller.
 * assumes: bound to pmw_power_ctrl; every signal belongs to CLK_I.
 */
`timescale 1ns/10ps

module pmw_power_ctrl_checker (
	input wire logic CLK_I,
	input wire logic SRST_I,
	input wire logic S_AXI_AWVALID_I,
	input wire logic S_AXI_AWREADY_O,
	input wire logic S_AXI_WVALID_I,
	input wire logic S_AXI_WREADY_O,
	input wire logic [1:0] S_AXI_BRESP_O,
	input wire logic S_AXI_BVALID_O,
	input wire logic S_AXI_BREADY_I,
	input wire logic S_AXI_ARVALID_I,
	input wire logic S_AXI_ARREADY_O,
	input wire logic [31:0] S_AXI_RDATA_O,
	input wire logic S_AXI_RVALID_O,
	input wire logic S_AXI_RREADY_I,
	input wire logic CPU_CLK_EN_O,
	input wire logic PERIPH_CLK_EN_O,
	input wire logic PRI_OSC_EN_O,
	input wire logic REMAP_OTHERS_EN_O,
	input wire logic ULP_WAKE_OUT_O,
	input wire logic ULP_IRQ_O,
	input wire logic RESUME_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (SRST_I);

	// ==========================================================
	// bus answers
	AST_B_LAT: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
		|-> ##[1:2] S_AXI_BVALID_O) else $error("write answer late");
	AST_B_HOLD: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
		else $error("write answer dropped");
	AST_R_LAT: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
		else $error("read answer late");
	AST_R_HOLD: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
		else $error("read answer dropped");

	// ==========================================================
	// modes and wake
	AST_SLEEP_CLK: assert property (!REMAP_OTHERS_EN_O && !$past(REMAP_OTHERS_EN_O)
		|-> !CPU_CLK_EN_O && !PERIPH_CLK_EN_O && !PRI_OSC_EN_O) else $error("clock running in sleep");
	AST_IRQ_CAUSE: assert property ($rose(ULP_WAKE_OUT_O) |-> ##[0:2] ULP_IRQ_O)
		else $error("pin edge gave no interrupt");
	AST_IRQ_ONE: assert property (ULP_IRQ_O |=> !ULP_IRQ_O)
		else $error("interrupt pulse too long");
	AST_RESUME_CPU: assert property (RESUME_O |=> !RESUME_O && CPU_CLK_EN_O)
		else $error("resume without cpu clock");

	cover property (ULP_IRQ_O);
	cover property (RESUME_O);
	cover property (!REMAP_OTHERS_EN_O);
endmodule

bind pmw_power_ctrl pmw_power_ctrl_checker u_chk (.CLK_I, .SRST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
	.S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARVALID_I,
	.S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I, .CPU_CLK_EN_O, .PERIPH_CLK_EN_O,
	.PRI_OSC_EN_O, .REMAP_OTHERS_EN_O, .ULP_WAKE_OUT_O, .ULP_IRQ_O, .RESUME_O);

// ---- sim/pmw_rc_net.sv ----
/*
 * pmw_rc_net: capacitor on the wake pin with its charge path and the sink.
 * assumes: charge from the bench, sink from the block, both on clk_i.
 */
`timescale 1ns/10ps

module pmw_rc_net #(
	parameter int LOW_LVL = 100
) (
	input wire logic clk_i,
	input wire logic charge_i,
	input wire logic sink_i,
	output logic low_o
);
	int cap = 0;

	always @(posedge clk_i) begin
		if (charge_i) begin
			cap <= (cap < 255) ? cap + 1 : cap;
		end else if (sink_i && cap > 0) begin
			cap <= cap - 1;
		end
	end

	// slow fall: comparator trips only once the level is under the threshold
	assign low_o = (cap < LOW_LVL);
endmodule

// ---- sim/testbench.sv ----
/*
 * testbench: register, sleep, idle and wake scenarios of pmw_power_ctrl.
 * assumes: pmw_pkg compiled first; rc network model drives the pin comparator.
 */
`timescale 1ns/10ps

module testbench;
	logic clk = 0, srst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, slp = 0, charge = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [2:0] wev = 3'h0;
	logic awready, wready, bvalid, arready, rvalid, cpu, per, pri, t1, io, rc, sink, wout, remap, irq, res, low;
	logic [1:0] bresp, rresp, sel, src;
	logic [31:0] rdata;
	logic [31:0] rq[$], mq[$], pq[$], bq[$];
	int miscompares = 0, checked = 0;

	pmw_power_ctrl #(.PRI_START_CYC(8'h20), .T1_START_CYC(8'h04), .INT_START_CYC(8'h04)) dut (
		.CLK_I(clk), .SRST_I(srst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
		.S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
		.S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr),
		.S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
		.S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .SLEEP_EXEC_I(slp), .WAKE_INT_I(wev[0]),
		.WAKE_RST_I(wev[1]), .WDT_TIMEOUT_I(wev[2]), .ANALOG_WAKE_LOW_I(low), .CPU_CLK_EN_O(cpu),
		.PERIPH_CLK_EN_O(per), .SYS_CLK_SEL_O(sel), .PRI_OSC_EN_O(pri), .T1_OSC_EN_O(t1), .INT_OSC_EN_O(io),
		.RC_OSC_EN_O(rc), .ULP_SINK_EN_O(sink), .ULP_WAKE_OUT_O(wout), .REMAP_OTHERS_EN_O(remap),
		.ULP_IRQ_O(irq), .RESUME_O(res));
	pmw_rc_net rc_net (.clk_i(clk), .charge_i(charge), .sink_i(sink), .low_o(low));

	initial begin
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// shared tasks
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic clks(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = pmw_pkg::RESP_OKAY);
		bit ad, wd;
		bq.push_back(32'(r));
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		ad = 0;
		wd = 0;
		while (!(ad && wd)) begin
			@(posedge clk);
			if (awvalid && awready) begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		// a late bready exercises the held answer
		clks($urandom_range(0, 2));
		bready <= 1'b1;
		@(posedge clk);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] p = pmw_pkg::RESP_OKAY);
		rq.push_back(e & m);
		mq.push_back(m);
		pq.push_back(32'(p));
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1) @(posedge clk);
		clks($urandom_range(0, 2));
		rready <= 1'b1;
		@(posedge clk);
		rready <= 1'b0;
	endtask

	task automatic sleep_now();
		slp <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		clks(3);
	endtask

	task automatic wake(input int i);
		wev[i] <= 1'b1;
		@(posedge clk);
		wev <= 3'h0;
	endtask

	task automatic waitfor(input bit k);
		int n;
		n = 0;
		while ((k ? irq : res) !== 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		if (n >= 400) begin
			miscompares++;
			$display("wait expired at %0t", $time);
		end
	endtask

	task automatic charge_pin();
		charge <= 1'b1;
		clks($urandom_range(150, 250));
		charge <= 1'b0;
		@(posedge clk);
	endtask

	task automatic results();
		$display("comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ==========================================================
	// answer watcher
	always @(posedge clk) begin
		if (bvalid && bready) begin
			chk(32'(bresp), bq.pop_front());
		end
		if (rvalid && rready) begin
			chk(rdata & mq.pop_front(), rq.pop_front());
			chk(32'(rresp), pq.pop_front());
		end
	end

	initial begin
		clks(20000);
		miscompares++;
		results();
	end

	// ==========================================================
	// scenarios
	initial begin
		void'($urandom(32'h47EA0B5F));
		clks(16);
		srst <= 1'b0;
		clks(1);
		rd(pmw_pkg::OSC_CTRL_ADDR, 32'h0, 32'h83);
		rd(8'h20, 32'h0, 32'hFFFFFFFF, pmw_pkg::RESP_DECERR);
		wr(8'h20, $urandom, pmw_pkg::RESP_DECERR);
		clks(80);
		rd(pmw_pkg::OSC_CTRL_ADDR, 32'h8, 32'h8);
		$display("reset test done");
		for (int i = 0; i < 3; i++) begin
			src = (i == 2) ? pmw_pkg::SRC_PRIMARY : 2'(i + 1);
			wr(pmw_pkg::OSC_CTRL_ADDR, {30'h0, src});
			clks(80);
			chk(32'(sel), 32'(src));
			rd(pmw_pkg::STATUS_ADDR, {26'h0, src, 4'h0}, 32'h37);
			rd(pmw_pkg::OSC_CTRL_ADDR, (src == pmw_pkg::SRC_PRIMARY) ? 32'h8 : {30'h0, src}, 32'hB);
		end
		$display("clock switch test done");
		wr(pmw_pkg::OSC_CTRL_ADDR, 32'h80);
		for (int i = 0; i < 3; i++) begin
			sleep_now();
			chk({cpu, per}, 32'h1);
			wake(i);
			waitfor(0);
			clks(2);
			chk(cpu, 32'h1);
		end
		rd(pmw_pkg::OSC_CTRL_ADDR, 32'h80, 32'h83);
		wr(pmw_pkg::OSC_CTRL_ADDR, 32'h0);
		$display("idle test done");
		wr(pmw_pkg::WDT_CTRL_ADDR, 32'h1);
		wr(pmw_pkg::PWR_CFG_ADDR, 32'h8);
		charge_pin();
		wr(pmw_pkg::WDT_CTRL_ADDR, 32'h7);
		sleep_now();
		chk({cpu, per, pri, rc, t1, remap, sink}, 32'hD);
		waitfor(1);
		chk(wout, 32'h1);
		clks(4);
		chk(cpu, 32'h0);
		waitfor(0);
		rd(pmw_pkg::WDT_CTRL_ADDR, 32'h20, 32'h20);
		rd(pmw_pkg::WDT_CTRL_ADDR, 32'h20, 32'h20);
		rd(pmw_pkg::OSC_CTRL_ADDR, 32'h0, 32'h83);
		wr(pmw_pkg::WDT_CTRL_ADDR, 32'h21);
		rd(pmw_pkg::WDT_CTRL_ADDR, 32'h1, 32'h27);
		$display("sleep wake test done");
		wr(pmw_pkg::PWR_CFG_ADDR, 32'h1);
		charge_pin();
		wr(pmw_pkg::WDT_CTRL_ADDR, 32'h6);
		sleep_now();
		chk({cpu, per}, 32'h0);
		waitfor(1);
		waitfor(0);
		rd(pmw_pkg::DS_WAKE_ADDR, 32'h20, 32'h20);
		wr(pmw_pkg::DS_WAKE_ADDR, 32'h20);
		rd(pmw_pkg::DS_WAKE_ADDR, 32'h0, 32'h20);
		wr(pmw_pkg::WDT_CTRL_ADDR, 32'h0);
		$display("deep sleep test done");
		wr(pmw_pkg::PWR_CFG_ADDR, 32'h2);
		sleep_now();
		wake(2);
		clks(12);
		chk({cpu, io, sel}, {28'h0, 1'b1, 1'b1, pmw_pkg::SRC_INTERNAL});
		waitfor(0);
		wr(pmw_pkg::PWR_CFG_ADDR, 32'h0);
		$display("two speed test done");
		results();
	end
endmodule
